// ### output_switch_ctrl.sv
`timescale 1ns/10ps

module output_switch_ctrl #(
  parameter int TICK_CYCLES = outsw_pkg::SLOW_TICK_CYCLES
) (
  input  wire logic       clk_sys,                  // Master clock
  input  wire logic       rst,                      // Sync reset, high
  input  wire logic       reg_wr_en,                // Control port write
  input  wire logic       reg_rd_en,                // Control port read
  input  wire logic [6:0] reg_addr,                 // Register address
  input  wire logic [8:0] reg_wdata,                // Write data
  input  wire logic       chip_select_or_switch_pin, // Jack sense level
  input  wire logic       over_temp,                // Thermal sensor level
  output logic      [8:0] reg_rdata,                // Read data
  output logic            speaker_out_pos_en,       // Positive speaker on
  output logic            speaker_out_neg_en,       // Negative speaker on
  output logic            mono_output_pin_en,       // Mono output on
  output logic            mono_mute_dc_ref,         // Mono as DC reference
  output logic            speaker_mixer_en,         // Speaker mixer on
  output logic            mono_mixer_en,            // Mono mixer on
  output logic            output_tieoff_high,       // High-ohm tie-off
  output logic            video_amp_enable,         // Video buffer on
  output logic            video_gain_select,        // 0: 0dB, 1: 6dB
  output logic            video_offset_disable,     // Allow drive to ground
  output logic            video_input_pulldown,     // Input pulldown on
  output logic            video_clamp_enable,       // Sync-tip clamp on
  output logic            filter_q_raise,           // Filter Q raised
  output logic            thermal_trip_enable,      // Thermal shutdown armed
  output logic            thermal_event,            // Over-temp pulse
  output logic            slow_tick                 // Zero-cross timeout tick
);

  logic [8:0] output_power_enables_ff;
  logic [8:0] additional_control_ff;
  logic [8:0] pin_function_control_ff;
  logic [8:0] video_amp_control_ff;
  logic [8:0] output_misc_control_ff;
  logic [8:0] mono_mixer_control_ff;
  logic [8:0] rdata_ff;

  logic       spk_pos_ff;
  logic       spk_neg_ff;
  logic       mono_ff;
  logic       therm_seen_ff;
  logic       therm_evt_ff;
  logic       tick_ff;

  logic       switch_mode;
  logic       raw_level;
  logic       stable_level;
  logic       tick;
  logic [2:0] pin_function_select;

  // Register writes from the control port
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      output_power_enables_ff <= outsw_pkg::RST_OUTPUT_POWER_ENABLES;
      additional_control_ff   <= outsw_pkg::RST_ADDITIONAL_CONTROL;
      pin_function_control_ff <= outsw_pkg::RST_PIN_FUNCTION_CONTROL;
      video_amp_control_ff    <= outsw_pkg::RST_VIDEO_AMP_CONTROL;
      output_misc_control_ff  <= outsw_pkg::RST_OUTPUT_MISC_CONTROL;
      mono_mixer_control_ff   <= outsw_pkg::RST_MONO_MIXER_CONTROL;
    end
    else if (reg_wr_en)
    begin
      case (reg_addr)
        outsw_pkg::ADDR_OUTPUT_POWER_ENABLES:
          output_power_enables_ff <= reg_wdata;
        outsw_pkg::ADDR_ADDITIONAL_CONTROL:
          additional_control_ff <= reg_wdata;
        outsw_pkg::ADDR_PIN_FUNCTION_CONTROL:
          pin_function_control_ff <= reg_wdata;
        outsw_pkg::ADDR_VIDEO_AMP_CONTROL:
          video_amp_control_ff <= reg_wdata;
        outsw_pkg::ADDR_OUTPUT_MISC_CONTROL:
          output_misc_control_ff <= reg_wdata;
        outsw_pkg::ADDR_MONO_MIXER_CONTROL:
          mono_mixer_control_ff <= reg_wdata;
        default:
          ;
      endcase
    end
  end

  // Read-back; unmapped addresses answer zero
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_ff <= 9'h000;
    else if (reg_rd_en)
    begin
      case (reg_addr)
        outsw_pkg::ADDR_OUTPUT_POWER_ENABLES:
          rdata_ff <= output_power_enables_ff;
        outsw_pkg::ADDR_ADDITIONAL_CONTROL:
          rdata_ff <= additional_control_ff;
        outsw_pkg::ADDR_PIN_FUNCTION_CONTROL:
          rdata_ff <= pin_function_control_ff;
        outsw_pkg::ADDR_VIDEO_AMP_CONTROL:
          rdata_ff <= video_amp_control_ff;
        outsw_pkg::ADDR_OUTPUT_MISC_CONTROL:
          rdata_ff <= output_misc_control_ff;
        outsw_pkg::ADDR_MONO_MIXER_CONTROL:
          rdata_ff <= mono_mixer_control_ff;
        default:
          rdata_ff <= 9'h000;
      endcase
    end
  end

  // Jack sense decode; the pin is read the same way whichever control
  // port mode is strapped, so nothing here looks at that mode
  assign pin_function_select =
    pin_function_control_ff[outsw_pkg::POS_PIN_FUNCTION_SELECT +: 3];
  assign switch_mode =
    (pin_function_select == outsw_pkg::PIN_FUNC_JACK_SWITCH);
  assign raw_level = chip_select_or_switch_pin ^
    pin_function_control_ff[outsw_pkg::BIT_SWITCH_INPUT_POLARITY];

  // Slow tick and de-bounce filter
  sw_debounce #(
    .TICK_CYCLES (TICK_CYCLES),
    .SAMPLES     (outsw_pkg::DEBOUNCE_SAMPLES)
  ) u_debounce (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .tick_en      (additional_control_ff[outsw_pkg::BIT_SLOW_TICK_ENABLE]),
    .raw_level    (raw_level),
    .tick         (tick),
    .stable_level (stable_level)
  );

  // Output gating: switching never turns on a disabled output
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      spk_pos_ff <= 1'b0;
      spk_neg_ff <= 1'b0;
      mono_ff    <= 1'b0;
    end
    else if (!switch_mode)
    begin
      spk_pos_ff <=
        output_power_enables_ff[outsw_pkg::BIT_SPEAKER_POS_ENABLE];
      spk_neg_ff <=
        output_power_enables_ff[outsw_pkg::BIT_SPEAKER_NEG_ENABLE];
      mono_ff <= output_power_enables_ff[outsw_pkg::BIT_MONO_OUTPUT_ENABLE];
    end
    else if (stable_level)
    begin
      spk_pos_ff <= 1'b0;
      spk_neg_ff <= 1'b0;
      mono_ff <=
        output_power_enables_ff[outsw_pkg::BIT_MONO_OUTPUT_ENABLE];
    end
    else
    begin
      spk_pos_ff <=
        output_power_enables_ff[outsw_pkg::BIT_SPEAKER_POS_ENABLE];
      spk_neg_ff <=
        output_power_enables_ff[outsw_pkg::BIT_SPEAKER_NEG_ENABLE];
      mono_ff <= 1'b0;
    end
  end

  // Over-temperature rising edge, only while shutdown is armed
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      therm_seen_ff <= 1'b0;
      therm_evt_ff  <= 1'b0;
    end
    else
    begin
      therm_seen_ff <= over_temp;
      therm_evt_ff  <= over_temp && !therm_seen_ff &&
        output_misc_control_ff[outsw_pkg::BIT_THERMAL_TRIP_ENABLE];
    end
  end

  // Tick re-timed so every top output leaves a flop here
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      tick_ff <= 1'b0;
    else
      tick_ff <= tick;
  end

  assign reg_rdata            = rdata_ff;
  assign speaker_out_pos_en   = spk_pos_ff;
  assign speaker_out_neg_en   = spk_neg_ff;
  assign mono_output_pin_en   = mono_ff;
  // Mute keeps the mono pin at the speaker DC level for capless use
  assign mono_mute_dc_ref     =
    mono_mixer_control_ff[outsw_pkg::BIT_MONO_MUTE_DC_REF];
  assign speaker_mixer_en     =
    output_power_enables_ff[outsw_pkg::BIT_SPEAKER_MIXER_ENABLE];
  assign mono_mixer_en        =
    output_power_enables_ff[outsw_pkg::BIT_MONO_MIXER_ENABLE];
  assign output_tieoff_high   =
    output_misc_control_ff[outsw_pkg::BIT_OUTPUT_TIEOFF_HIGH];
  assign video_amp_enable     =
    output_power_enables_ff[outsw_pkg::BIT_VIDEO_AMP_ENABLE];
  assign video_gain_select    =
    video_amp_control_ff[outsw_pkg::BIT_VIDEO_GAIN_SELECT];
  assign video_offset_disable =
    video_amp_control_ff[outsw_pkg::BIT_VIDEO_OFFSET_DISABLE];
  assign video_input_pulldown =
    video_amp_control_ff[outsw_pkg::BIT_VIDEO_INPUT_PULLDOWN];
  // Software must set this when the input is AC coupled
  assign video_clamp_enable   =
    video_amp_control_ff[outsw_pkg::BIT_VIDEO_CLAMP_ENABLE];
  assign filter_q_raise       =
    video_amp_control_ff[outsw_pkg::BIT_FILTER_Q_RAISE];
  assign thermal_trip_enable  =
    output_misc_control_ff[outsw_pkg::BIT_THERMAL_TRIP_ENABLE];
  assign thermal_event        = therm_evt_ff;
  assign slow_tick            = tick_ff;

endmodule

// ### outsw_pkg.sv
package outsw_pkg;

  // Register addresses on the control port (7-bit)
  localparam logic [6:0] ADDR_OUTPUT_POWER_ENABLES = 7'h03;
  localparam logic [6:0] ADDR_ADDITIONAL_CONTROL   = 7'h07;
  localparam logic [6:0] ADDR_PIN_FUNCTION_CONTROL = 7'h08;
  localparam logic [6:0] ADDR_VIDEO_AMP_CONTROL    = 7'h28;
  localparam logic [6:0] ADDR_OUTPUT_MISC_CONTROL  = 7'h31;
  localparam logic [6:0] ADDR_MONO_MIXER_CONTROL   = 7'h38;

  // output_power_enables fields
  localparam int BIT_MONO_OUTPUT_ENABLE  = 7;
  localparam int BIT_SPEAKER_NEG_ENABLE  = 6;
  localparam int BIT_SPEAKER_POS_ENABLE  = 5;
  localparam int BIT_VIDEO_AMP_ENABLE    = 4;
  localparam int BIT_MONO_MIXER_ENABLE   = 3;
  localparam int BIT_SPEAKER_MIXER_ENABLE = 2;

  // additional_control fields
  localparam int BIT_SLOW_TICK_ENABLE    = 0;

  // pin_function_control fields
  localparam int BIT_SWITCH_INPUT_POLARITY = 3;
  localparam int POS_PIN_FUNCTION_SELECT   = 0;
  localparam logic [2:0] PIN_FUNC_JACK_SWITCH = 3'h1;

  // video_amp_control fields
  localparam int BIT_FILTER_Q_RAISE        = 4;
  localparam int BIT_VIDEO_GAIN_SELECT     = 3;
  localparam int BIT_VIDEO_OFFSET_DISABLE  = 2;
  localparam int BIT_VIDEO_INPUT_PULLDOWN  = 1;
  localparam int BIT_VIDEO_CLAMP_ENABLE    = 0;

  // output_misc_control fields
  localparam int BIT_THERMAL_TRIP_ENABLE   = 1;
  localparam int BIT_OUTPUT_TIEOFF_HIGH    = 0;

  // mono mixer control fields
  localparam int BIT_MONO_MUTE_DC_REF      = 6;

  // Reset values
  localparam logic [8:0] RST_OUTPUT_POWER_ENABLES = 9'h000;
  localparam logic [8:0] RST_ADDITIONAL_CONTROL   = 9'h000;
  localparam logic [8:0] RST_PIN_FUNCTION_CONTROL = 9'h000;
  localparam logic [8:0] RST_VIDEO_AMP_CONTROL    = 9'h000;
  localparam logic [8:0] RST_OUTPUT_MISC_CONTROL  = 9'h002;
  localparam logic [8:0] RST_MONO_MIXER_CONTROL   = 9'h000;

  // Slow tick: period in master clock cycles (2^21)
  localparam int SLOW_TICK_CYCLES = 2097152;
  // Equal samples needed after the first one before the level is accepted
  localparam int DEBOUNCE_SAMPLES = 2;

endpackage

// ### sw_debounce.sv
`timescale 1ns/10ps

// Slow tick divider plus sample-and-compare de-bounce filter
module sw_debounce #(
  parameter int TICK_CYCLES = outsw_pkg::SLOW_TICK_CYCLES,
  parameter int SAMPLES     = outsw_pkg::DEBOUNCE_SAMPLES
) (
  input  wire logic clk_sys,       // Master clock
  input  wire logic rst,           // Synchronous reset, active high
  input  wire logic tick_en,       // Slow tick enable
  input  wire logic raw_level,     // Effective switch level, undebounced
  output logic      tick,          // One-cycle slow tick pulse
  output logic      stable_level   // De-bounced level
);

  localparam int CW = $clog2(TICK_CYCLES);
  localparam int SW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);
  localparam logic [SW-1:0] SAMP_LAST = SW'(SAMPLES - 1);

  logic [CW-1:0] div_ff;
  logic          tick_ff;
  logic          last_ff;
  logic [SW-1:0] same_ff;
  logic          stable_ff;

  // Divider is cleared while disabled so no tick leaks out
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else if (!tick_en)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else if (div_ff == TICK_LAST)
    begin
      div_ff  <= '0;
      tick_ff <= 1'b1;
    end
    else
    begin
      div_ff  <= div_ff + CW'(1);
      tick_ff <= 1'b0;
    end
  end

  // Level is accepted only after equal samples on consecutive ticks;
  // a glitch shorter than a tick period cannot flip the output at all
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      last_ff   <= 1'b0;
      same_ff   <= '0;
      stable_ff <= 1'b0;
    end
    else if (tick_ff)
    begin
      last_ff <= raw_level;
      if (raw_level != last_ff)
        same_ff <= '0;
      else if (same_ff != SAMP_LAST)
        same_ff <= same_ff + SW'(1);
      else
        stable_ff <= raw_level;
    end
  end

  assign tick         = tick_ff;
  assign stable_level = stable_ff;

endmodule

// ### jack_switch_model.sv
`timescale 1ns/10ps
// Mechanical jack contact that chatters after every plug change
module jack_switch_model (
  input  wire logic clk_sys, // Clock
  input  wire logic plugged, // Plug state
  input  wire logic glitch,  // Forced spike
  output logic      pin      // Contact level
);
  logic       last_ff   = 1'b0; // Plug state seen
  logic [2:0] bounce_ff = 3'h0; // Chatter cycles left
  // Chatter is shorter than one slow tick, as a real contact
  always_ff @(posedge clk_sys)
  begin
    last_ff <= plugged;
    if (plugged != last_ff)
      bounce_ff <= 3'h5;
    else if (bounce_ff != 3'h0)
      bounce_ff <= bounce_ff - 3'h1;
  end
  assign pin = plugged ^ glitch ^ bounce_ff[0];
endmodule

// ### outsw_sva.sv
`timescale 1ns/10ps
module outsw_sva #(
  parameter int TICK_CYCLES = 8
) (
  input wire logic       clk_sys,              // Clock
  input wire logic       rst,                  // Reset
  input wire logic       reg_wr_en,            // Write
  input wire logic       reg_rd_en,            // Read
  input wire logic [6:0] reg_addr,             // Address
  input wire logic [8:0] reg_wdata,            // Write data
  input wire logic       over_temp,            // Sensor
  input wire logic [8:0] reg_rdata,            // Read data
  input wire logic       speaker_out_pos_en,   // Speaker +
  input wire logic       speaker_out_neg_en,   // Speaker -
  input wire logic       mono_output_pin_en,   // Mono
  input wire logic       video_amp_enable,     // Video on
  input wire logic       video_gain_select,    // Gain
  input wire logic       video_offset_disable, // Offset off
  input wire logic       video_input_pulldown, // Pulldown
  input wire logic       video_clamp_enable,   // Clamp
  input wire logic       filter_q_raise,       // Q raise
  input wire logic       thermal_trip_enable,  // Trip armed
  input wire logic       thermal_event,        // Trip pulse
  input wire logic       slow_tick             // Tick
);
  logic [8:0] pe_ff;   // Power enable shadow
  logic [8:0] pe_d_ff; // Same, one cycle late
  logic [4:0] vd_ff;   // Video field shadow
  logic       sw_ff;   // Switch mode shadow
  logic       en_ff;   // Tick enable shadow
  int         gap_ff;  // Cycles since a tick
  logic       mapped;  // Address decodes
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign mapped = reg_addr inside {7'h03, 7'h07, 7'h08, 7'h28, 7'h31, 7'h38};
  // Shadows rebuilt from port writes, so no body access is needed
  always_ff @(posedge clk_sys)
  begin
    pe_d_ff <= pe_ff;
    if (rst)
    begin
      pe_ff <= 9'h000;
      vd_ff <= 5'h00;
      sw_ff <= 1'b0;
      en_ff <= 1'b0;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == 7'h03)
        pe_ff <= reg_wdata;
      if (reg_addr == 7'h28)
        vd_ff <= reg_wdata[4:0];
      if (reg_addr == 7'h08)
        sw_ff <= reg_wdata[2:0] == 3'h1;
      if (reg_addr == 7'h07)
        en_ff <= reg_wdata[0];
    end
  end
  // Tick spacing counter
  always_ff @(posedge clk_sys)
  begin
    if (rst || slow_tick)
      gap_ff <= 0;
    else
      gap_ff <= gap_ff + 1;
  end
  sequence pulse_s;
    thermal_event ##1 !thermal_event;
  endsequence
  a_reset_values:
    assert property ($fell(rst) |-> thermal_trip_enable && !video_amp_enable)
    else $error("Reset values wrong");
  a_amp_field:
    assert property (video_amp_enable == pe_ff[4])
    else $error("Video amp enable wrong");
  a_video_fields:
    assert property ({filter_q_raise, video_gain_select, video_offset_disable,
      video_input_pulldown, video_clamp_enable} == vd_ff)
    else $error("Video fields wrong");
  a_video_readback:
    assert property (reg_rd_en && reg_addr == 7'h28
      |=> reg_rdata[4:0] == $past(vd_ff))
    else $error("Video readback wrong");
  a_unmapped_read:
    assert property (reg_rd_en && !mapped |=> reg_rdata == 9'h000)
    else $error("Unmapped read not zero");
  a_trip_pulse:
    assert property ($rose(over_temp) && thermal_trip_enable |=> pulse_s)
    else $error("Thermal pulse missing");
  a_trip_gated:
    assert property (thermal_event |-> $past(thermal_trip_enable))
    else $error("Thermal pulse while off");
  a_switch_excl:
    assert property (sw_ff && $past(sw_ff) |-> !(mono_output_pin_en
      && (speaker_out_pos_en || speaker_out_neg_en)))
    else $error("Mono and speaker both on");
  a_enable_gate:
    assert property (!(speaker_out_pos_en && !pe_d_ff[5])
      && !(speaker_out_neg_en && !pe_d_ff[6])
      && !(mono_output_pin_en && !pe_d_ff[7]))
    else $error("Output on with bit clear");
  a_plain_follow:
    assert property (!sw_ff && !$past(sw_ff) |-> {mono_output_pin_en,
      speaker_out_neg_en, speaker_out_pos_en} == pe_d_ff[7:5])
    else $error("Enables not following bits");
  a_tick_spacing:
    assert property (slow_tick |-> gap_ff >= TICK_CYCLES - 1)
    else $error("Ticks too close");
  a_tick_gated:
    assert property (!en_ff && !$past(en_ff) && !$past(en_ff, 2)
      |-> !slow_tick)
    else $error("Tick while disabled");
endmodule
bind output_switch_ctrl outsw_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clk_sys(clk_sys), .rst(rst), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .over_temp(over_temp), .reg_rdata(reg_rdata),
  .speaker_out_pos_en(speaker_out_pos_en),
  .speaker_out_neg_en(speaker_out_neg_en),
  .mono_output_pin_en(mono_output_pin_en),
  .video_amp_enable(video_amp_enable), .video_gain_select(video_gain_select),
  .video_offset_disable(video_offset_disable),
  .video_input_pulldown(video_input_pulldown),
  .video_clamp_enable(video_clamp_enable), .filter_q_raise(filter_q_raise),
  .thermal_trip_enable(thermal_trip_enable),
  .thermal_event(thermal_event), .slow_tick(slow_tick));

// ### output_switch_ctrl_bench.sv
`timescale 1ns/10ps
module output_switch_ctrl_bench;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        wr_en   = 1'b0;
  logic        rd_en   = 1'b0;
  logic [6:0]  addr    = 7'h00;
  logic [8:0]  wdata   = 9'h000;
  logic        hot     = 1'b0;
  logic        plugged = 1'b0;
  logic        glitch  = 1'b0;
  logic [31:0] seed    = 32'hEF5A;
  logic        pin, spk_p, spk_n, mono, dc_ref, trip_ev, tick;
  logic        spk_mix, mono_mix, tie;
  logic [8:0]  rdata, pe;
  int          n_errors = 0, num_checks = 0, n;
  // 10 MHz master clock
  always #50 clk_sys = ~clk_sys;
  output_switch_ctrl #(.TICK_CYCLES(8)) DUT (
    .clk_sys(clk_sys), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .chip_select_or_switch_pin(pin),
    .over_temp(hot), .reg_rdata(rdata), .speaker_out_pos_en(spk_p),
    .speaker_out_neg_en(spk_n), .mono_output_pin_en(mono),
    .mono_mute_dc_ref(dc_ref), .speaker_mixer_en(spk_mix),
    .mono_mixer_en(mono_mix), .output_tieoff_high(tie),
    .video_amp_enable(), .video_gain_select(),
    .video_offset_disable(), .video_input_pulldown(),
    .video_clamp_enable(), .filter_q_raise(), .thermal_trip_enable(),
    .thermal_event(trip_ev), .slow_tick(tick));
  jack_switch_model u_jack (.clk_sys(clk_sys), .plugged(plugged),
    .glitch(glitch), .pin(pin));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Expected {mono, speaker -, speaker +} from mode, level and bits
  function automatic logic [2:0] exp_en(input logic sw, pol, lvl,
                                        input logic [8:0] bits);
    if (!sw)
      return bits[7:5];
    if (lvl ^ pol)
      return {bits[7], 2'b00};
    return {1'b0, bits[6:5]};
  endfunction
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic cycles(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  // One-cycle strobes, launched and dropped on falling edges
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] want);
    @(negedge clk_sys);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk_sys);
    rd_en = 1'b0;
    chk(rdata, want);
  endtask
  task automatic en_is(input logic [2:0] e);
    chk({6'h00, mono, spk_n, spk_p}, {6'h00, e});
  endtask
  task automatic wait_tick;
    n = 0;
    while (tick !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50)
    begin
      n_errors++;
      final_report;
    end
  endtask
  initial
  begin
    cycles(6);
    rst = 1'b0;
    rd(7'h31, 9'h002);
    rd(7'h03, 9'h000);
    rd(7'h28, 9'h000);
    rd(7'h15, 9'h000);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr(7'h28, seed[8:0]);
      rd(7'h28, seed[8:0]);
    end
    for (int e = 0; e < 2; e++)
    begin
      wr(7'h31, {7'h00, e[0], e[0]});
      chk({8'h00, tie}, {8'h00, e[0]});
      hot = 1'b1;
      cycles(1);
      chk({8'h00, trip_ev}, {8'h00, e[0]});
      cycles(1);
      chk({8'h00, trip_ev}, 9'h000);
      hot = 1'b0;
    end
    wr(7'h07, 9'h001);
    wait_tick;
    cycles(1);
    wait_tick;
    chk(9'(n), 9'h007);
    // Every polarity, level, mono enable and paired speaker enable combination in switch mode
    for (int k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      pe = {1'b0, k[3], k[2], k[2], seed[4:0]};
      plugged = k[1];
      wr(7'h08, {5'h00, k[0], 3'h1});
      wr(7'h03, pe);
      cycles(60);
      en_is(exp_en(1'b1, k[0], k[1], pe));
      chk({7'h00, mono_mix, spk_mix}, {7'h00, pe[3:2]});
    end
    // Glitch spans one or two ticks, never the three a change needs
    for (int g = 0; g < 40; g++)
    begin
      glitch = (g < 10);
      cycles(1);
      en_is(3'h3);
    end
    plugged = 1'b0;
    cycles(12);
    en_is(3'h3);
    cycles(50);
    en_is(3'h4);
    wr(7'h07, 9'h000);
    plugged = 1'b1;
    cycles(60);
    en_is(3'h4);
    wr(7'h07, 9'h001);
    cycles(60);
    en_is(3'h3);
    wr(7'h08, 9'h000);
    cycles(2);
    en_is(pe[7:5]);
    wr(7'h38, 9'h040);
    chk({8'h00, dc_ref}, 9'h001);
    final_report;
  end
endmodule
